//--- rtl/bad_defines.vh
// bad_defines.vh: constants for the board address decoder
// assumes inclusion by bare name from the rtl files
`ifndef BAD_DEFINES_VH
`define BAD_DEFINES_VH
// status line code meaning no cycle (passive)
`define BAD_ST_PASSIVE   3'h7
// status codes 0..3 are i/o-side cycles, 4..6 memory-side
`define BAD_ST_SPACE_BIT 2
// memory cycle codes: read 5, write 6, fetch 4
`define BAD_ST_IORD      3'h1
`define BAD_ST_IOWR      3'h2
`define BAD_ST_MEMWR     3'h6
// rom sizes: 0=8k 1=16k 2=32k 3=64k
`define BAD_ROM_8K       2'h0
// address bits of one 8k byte-wide part
`define BAD_ROM_MIN_BITS 5'hd
// two banks of two byte lanes above one part
`define BAD_ROM_SPAN_BITS 5'h2
// bank select bit sits one above the part's top bit
`define BAD_ROM_BANK_OFS 5'h1
// rom region top of 1 mbyte space, one bank per 2*size
`define BAD_ROM_TOP      20'hfffff
// ram size default 512k
`define BAD_RAM_TOP      20'h7ffff
// i/o page: eight-byte port blocks from 0x00c0, base in a[15:3]
`define BAD_IO_BASE      13'h0018
// i/o select indices
`define BAD_IO_SERIAL    4'h0
`define BAD_IO_TIMER     4'h1
`define BAD_IO_PARALLEL  4'h2
`define BAD_IO_INTC      4'h3
`define BAD_IO_XA0       4'h4
`define BAD_IO_XA1       4'h5
`define BAD_IO_XB0       4'h6
`define BAD_IO_XB1       4'h7
`define BAD_IO_STATUS    4'h8
`define BAD_IO_COUNT     9
// translation lookup index width
`define BAD_LUT_AW       10
`define BAD_LUT_DW       4
`endif

//--- rtl/bad_xlat_rom.v
// bad_xlat_rom.v: slave address range lookup, 10-bit index, registered out
// assumes index settles one cycle before data is used
`timescale 1ns/1ns
`include "bad_defines.vh"
module bad_xlat_rom #(
  parameter AW = `BAD_LUT_AW,
  parameter DW = `BAD_LUT_DW
) (
  input  wire          clk,
  input  wire [AW-1:0] index,
  output reg  [DW-1:0] xlatBits,
  output reg           rangeHit
);
  // index = {range setting 6b, incoming bits 4b}; hit when incoming
  // block lies at or below the jumpered top, translated = incoming + base
  wire [5:0] setting  = index[AW-1:4];
  wire [3:0] incoming = index[3:0];
  wire [3:0] base     = {2'h0, setting[5:4]};
  wire [3:0] top      = setting[3:0];
  always @(posedge clk) begin
    rangeHit <= (incoming <= top);
    xlatBits <= incoming + base;
  end
endmodule

//--- rtl/bad_io_decode.v
// bad_io_decode.v: on-board i/o port decode into nine selects
// assumes address valid while enable is high
`timescale 1ns/1ns
`include "bad_defines.vh"
module bad_io_decode (
  input  wire        enable,
  input  wire [15:0] addr,
  output reg  [8:0]  ioSel,
  output wire        ioHit
);
  reg [12:0] offset;
  reg [3:0]  slot;
  always @* begin
    ioSel  = 9'h000;
    offset = addr[15:3] - `BAD_IO_BASE;
    slot   = offset[3:0];
    // a0 and a3..af examined, eight bytes per select
    if (enable && addr[0] == 1'b0 && offset < `BAD_IO_COUNT)
      ioSel[slot] = 1'b1; // one of nine two per connector
  end
  assign ioHit = |ioSel;
endmodule

//--- rtl/bad_top.v
// bad_top.v: board address decoder and shared ram access steering
// assumes cpu status/address synchronous to clk; far side drives bus
// address before command strobes
`timescale 1ns/1ns
`include "bad_defines.vh"
// Behaviour
// - latch three status lines; space bit selects memory or i/o decode
// - memory decode raises at most one ram or rom select
// - i/o cycle raises one of nine peripheral selects
// - i/o decode uses a0 and a3..af; flags hit or not on-board
// - each expansion connector gets two separate selects
// - bus address is 20 bits, or 24 with page register enabled
// - bus address drive only after local bus acquisition
// - local ram hit plus command arbitrates; win gives gate and enable
// - command gate forwards local read/write to ram controller
// - rom hit enables command decode; memory read goes to rom
// - four rom enables: bank0/1 high and low bytes
// - rom sockets 8k..64k depth, default 8k
// - slave lookup of 10 bits; page compare by exclusive-or
// - offboard request only on lookup hit and page match
// - translated bits driven only with offboard drive enable
// - idle local side lets slave mode drive enable and slave gate
// - external masters never reach rom
// - shared ram defaults to local side when idle
// - overlay inhibit suppresses shared ram responses
module bad_top #(
  parameter ROM_SIZE = `BAD_ROM_8K
) (
  input  wire        clk,
  input  wire        rst,
  input  wire [2:0]  cpuStatus,
  input  wire [19:0] cpuAddr,
  input  wire        cpuCmd,
  input  wire        cpuBhe,
  input  wire        pageEnable,
  input  wire        pageLoad,
  input  wire [3:0]  pageData,
  input  wire        busGranted,
  input  wire [19:0] slvAddr,
  input  wire        slvRead,
  input  wire        slvWrite,
  input  wire [3:0]  slvPage,
  input  wire [5:0]  rangeSetting,
  input  wire        offboard_address_drive,
  input  wire        overlay_inhibit,
  output reg         spaceMem,
  output reg         ramSelect,
  output reg  [3:0]  romEnable,
  output reg         rom_hit,
  output reg         command_decode_enable,
  output reg         romRead,
  output reg  [8:0]  ioSelect,
  output reg         portHit,
  output reg         onboard_address_valid,
  output reg         status_register_select,
  output reg  [23:0] busAddr,
  output reg         bus_address_drive_enable,
  output reg         onboard_command_gate,
  output reg         slaveCommandGate,
  output reg         shared_ram_enable,
  output reg         local_shared_read,
  output reg         local_shared_write,
  output reg         ctrlRead,
  output reg         ctrlWrite,
  output reg         offboard_address_request,
  output reg  [3:0]  sharedHighAddr
);
  localparam S_IDLE  = 2'h0;
  localparam S_LOCAL = 2'h1;
  localparam S_SLAVE = 2'h2;

  reg  [2:0]  stLatch;
  reg  [19:0] addrLatch;
  reg  [3:0]  pageReg;
  reg  [1:0]  state;
  reg  [1:0]  next_state;
  wire [8:0]  ioSelW;
  wire        ioHitW;
  wire [3:0]  xlatBits;
  wire        rangeHit;

  // rom window width in address bits per socket (13..16)
  function [4:0] romBits;
    input [1:0] size;
    begin
      romBits = `BAD_ROM_MIN_BITS + {3'h0, size};
    end
  endfunction

  // true when addr lies in top 4*size bytes (two banks, two bytes)
  function isRom;
    input [19:0] a;
    input [1:0]  size;
    reg   [19:0] span;
    begin
      span  = 20'h00001 << (romBits(size) + `BAD_ROM_SPAN_BITS);
      isRom = a >= (`BAD_ROM_TOP - span + 20'h00001);
    end
  endfunction

  // memory write status code; every other memory code reads
  function isMemWrite;
    input [2:0] st;
    begin
      isMemWrite = (st == `BAD_ST_MEMWR);
    end
  endfunction

  // byte enables {b1hi, b1lo, b0hi, b0lo}: low lane on a0 low,
  // high lane on the active-low byte-high enable
  function [3:0] romByteEnables;
    input bank;
    input bhe;
    input a0;
    begin
      romByteEnables = {bank & ~bhe, bank & ~a0, ~bank & ~bhe, ~bank & ~a0};
    end
  endfunction

  wire cycleLive = (stLatch != `BAD_ST_PASSIVE);
  wire memCycle  = cycleLive && stLatch[`BAD_ST_SPACE_BIT];
  wire ioCycle   = cycleLive && !stLatch[`BAD_ST_SPACE_BIT];
  wire romW      = memCycle && isRom(addrLatch, ROM_SIZE);
  wire ramW      = memCycle && !romW && addrLatch <= `BAD_RAM_TOP;
  wire slvCmd    = slvRead || slvWrite;
  wire pageMatch = ~|(slvPage ^ pageReg);
  wire slvHit    = rangeHit && pageMatch;
  wire romBank   = addrLatch[romBits(ROM_SIZE) + `BAD_ROM_BANK_OFS];
  wire busCycle  = memCycle && !romW && !ramW;

  // status latch and page register
  always @(posedge clk) begin
    if (rst) begin
      stLatch   <= `BAD_ST_PASSIVE;
      addrLatch <= 20'h00000;
      pageReg   <= 4'h0;
    end else begin
      stLatch   <= cpuStatus;
      addrLatch <= cpuAddr;
      if (pageLoad)
        pageReg <= pageData;
    end
  end

  bad_io_decode u_io (
    .enable (ioCycle),
    .addr   (addrLatch[15:0]),
    .ioSel  (ioSelW),
    .ioHit  (ioHitW)
  );

  // slave range lookup: incoming address bits plus range setting
  bad_xlat_rom #(
    .AW (`BAD_LUT_AW),
    .DW (`BAD_LUT_DW)
  ) u_lut (
    .clk      (clk),
    .index    ({rangeSetting, slvAddr[13:10]}),
    .xlatBits (xlatBits),
    .rangeHit (rangeHit)
  );

  // shared ram arbitration, local side default
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (ramW && cpuCmd && !overlay_inhibit)
          next_state = S_LOCAL;
        else if (slvCmd && slvHit && !overlay_inhibit)
          next_state = S_SLAVE;
      end
      S_LOCAL: begin
        if (!(ramW && cpuCmd))
          next_state = S_IDLE;
      end
      S_SLAVE: begin
        if (!slvCmd)
          next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  // next output values, registered below
  reg         next_spaceMem;
  reg         next_ramSelect;
  reg  [3:0]  next_romEnable;
  reg         next_romHit;
  reg         next_cmdDecodeEnable;
  reg         next_romRead;
  reg  [8:0]  next_ioSelect;
  reg         next_portHit;
  reg         next_onboardValid;
  reg         next_statusSelect;
  reg  [23:0] next_busAddr;
  reg         next_busDrive;
  reg         next_onboardGate;
  reg         next_slaveGate;
  reg         next_sharedEnable;
  reg         next_localRead;
  reg         next_localWrite;
  reg         next_ctrlRead;
  reg         next_ctrlWrite;
  reg         next_offboardReq;
  reg  [3:0]  next_sharedHigh;

  // decode and steering from the latched cycle
  always @* begin
    next_spaceMem = memCycle;

    // memory decode: single select
    next_ramSelect       = ramW;
    next_romHit          = romW;
    next_cmdDecodeEnable = romW;
    next_romRead         = romW && cpuCmd && !isMemWrite(stLatch);
    next_romEnable       = 4'h0;
    // four byte/bank enables
    if (romW) begin
      next_romEnable = romByteEnables(romBank, cpuBhe, addrLatch[0]);
    end

    // i/o decode
    next_ioSelect     = ioSelW;
    next_statusSelect = ioSelW[`BAD_IO_STATUS];
    next_portHit      = ioHitW;
    next_onboardValid = ioHitW || romW || ramW;

    // paged bus address, only with bus granted
    next_busDrive = busGranted && busCycle;
    next_busAddr  = 24'h000000;
    if (next_busDrive) begin
      next_busAddr = {pageEnable ? pageReg : 4'h0, addrLatch};
    end

    // local side gates
    next_onboardGate  = next_state == S_LOCAL;
    next_slaveGate    = next_state == S_SLAVE;
    next_sharedEnable = next_state != S_IDLE;
    next_localRead    = next_onboardGate && !isMemWrite(stLatch);
    next_localWrite   = next_onboardGate && isMemWrite(stLatch);
    next_ctrlRead = next_localRead || (next_slaveGate && slvRead);
    next_ctrlWrite = next_localWrite || (next_slaveGate && slvWrite);

    // slave request: ram only, never rom
    next_offboardReq = slvCmd && slvHit && !overlay_inhibit;
    next_sharedHigh  = 4'h0;
    if (offboard_address_drive) begin
      next_sharedHigh = xlatBits;
    end
  end

  // arbitration state register
  always @(posedge clk) begin
    if (rst) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // registered outputs, all low during reset
  always @(posedge clk) begin
    if (rst) begin
      spaceMem                 <= 1'b0;
      ramSelect                <= 1'b0;
      romEnable                <= 4'h0;
      rom_hit                  <= 1'b0;
      command_decode_enable    <= 1'b0;
      romRead                  <= 1'b0;
      ioSelect                 <= 9'h000;
      portHit                  <= 1'b0;
      onboard_address_valid    <= 1'b0;
      status_register_select   <= 1'b0;
      busAddr                  <= 24'h000000;
      bus_address_drive_enable <= 1'b0;
      onboard_command_gate     <= 1'b0;
      slaveCommandGate         <= 1'b0;
      shared_ram_enable        <= 1'b0;
      local_shared_read        <= 1'b0;
      local_shared_write       <= 1'b0;
      ctrlRead                 <= 1'b0;
      ctrlWrite                <= 1'b0;
      offboard_address_request <= 1'b0;
      sharedHighAddr           <= 4'h0;
    end else begin
      spaceMem                 <= next_spaceMem;
      ramSelect                <= next_ramSelect;
      romEnable                <= next_romEnable;
      rom_hit                  <= next_romHit;
      command_decode_enable    <= next_cmdDecodeEnable;
      romRead                  <= next_romRead;
      ioSelect                 <= next_ioSelect;
      portHit                  <= next_portHit;
      onboard_address_valid    <= next_onboardValid;
      status_register_select   <= next_statusSelect;
      busAddr                  <= next_busAddr;
      bus_address_drive_enable <= next_busDrive;
      onboard_command_gate     <= next_onboardGate;
      slaveCommandGate         <= next_slaveGate;
      shared_ram_enable        <= next_sharedEnable;
      local_shared_read        <= next_localRead;
      local_shared_write       <= next_localWrite;
      ctrlRead                 <= next_ctrlRead;
      ctrlWrite                <= next_ctrlWrite;
      offboard_address_request <= next_offboardReq;
      sharedHighAddr           <= next_sharedHigh;
    end
  end
endmodule

//--- verif/bad_checker.sv
// bad_checker.sv: port assertions for bad_top
// assumes bind onto bad_top, one clock, sync active-high reset
`timescale 1ns/1ns
module bad_checker (
  input wire       clk,
  input wire       rst,
  input wire       busGranted,
  input wire       overlay_inhibit,
  input wire       spaceMem,
  input wire       ramSelect,
  input wire       rom_hit,
  input wire       command_decode_enable,
  input wire       romRead,
  input wire [8:0] ioSelect,
  input wire       bus_address_drive_enable,
  input wire       onboard_command_gate,
  input wire       slaveCommandGate,
  input wire       shared_ram_enable,
  input wire       ctrlRead,
  input wire       ctrlWrite,
  input wire       offboard_address_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_reset; $fell(rst) |-> ioSelect == 9'h0 && !ramSelect; endproperty
  a_reset: assert property (p_reset) else $error("select after reset");
  property p_space; spaceMem |-> ioSelect == 9'h0; endproperty
  a_space: assert property (p_space) else $error("io select in mem");
  property p_memone; !(ramSelect && rom_hit); endproperty
  a_memone: assert property (p_memone) else $error("two mem selects");
  property p_ioone; $onehot0(ioSelect); endproperty
  a_ioone: assert property (p_ioone) else $error("two io selects");
  property p_busen; $rose(bus_address_drive_enable) |-> $past(busGranted);
  endproperty
  a_busen: assert property (p_busen) else $error("drive before grant");
  property p_gate; onboard_command_gate |-> shared_ram_enable; endproperty
  a_gate: assert property (p_gate) else $error("gate without enable");
  property p_ctrl; ctrlRead || ctrlWrite |->
    onboard_command_gate || slaveCommandGate; endproperty
  a_ctrl: assert property (p_ctrl) else $error("ungated command");
  property p_romrd; romRead |-> command_decode_enable && rom_hit; endproperty
  a_romrd: assert property (p_romrd) else $error("rom read no hit");
  property p_off; offboard_address_request |-> !$past(overlay_inhibit);
  endproperty
  a_off: assert property (p_off) else $error("request when inhibited");
  property p_norom; slaveCommandGate |-> !romRead; endproperty
  a_norom: assert property (p_norom) else $error("slave reached rom");
endmodule
bind bad_top bad_checker i_bad_checker (.clk, .rst, .busGranted,
  .overlay_inhibit, .spaceMem, .ramSelect, .rom_hit, .command_decode_enable,
  .romRead, .ioSelect, .bus_address_drive_enable, .onboard_command_gate,
  .slaveCommandGate, .shared_ram_enable, .ctrlRead, .ctrlWrite,
  .offboard_address_request);

//--- verif/bad_partner.sv
// bad_partner.sv: external bus master and shared control model
// assumes clk of bad_top; access task called from the bench
`timescale 1ns/1ns
module bad_partner (
  input  wire        clk,
  input  wire        rst,
  input  wire        offboard_address_request,
  output reg  [19:0] slvAddr,
  output reg  [3:0]  slvPage,
  output reg         slvRead,
  output reg         slvWrite,
  output reg         offboard_address_drive
);
  initial begin
    slvAddr = 20'h0;
    slvPage = 4'h0;
    slvRead = 1'b0;
    slvWrite = 1'b0;
  end
  // drive enable follows request one edge later
  always @(posedge clk) begin
    offboard_address_drive <= !rst && offboard_address_request;
  end
  task access(input [19:0] a, input [3:0] pg, input wr);
    @(posedge clk);
    slvAddr <= a;
    slvPage <= pg;
    repeat (2) @(posedge clk);
    slvRead <= !wr;
    slvWrite <= wr;
    repeat (4) @(posedge clk);
    slvRead <= 1'b0;
    slvWrite <= 1'b0;
    @(posedge clk);
    slvAddr <= ~a;
  endtask
endmodule

//--- verif/tb_top.sv
// tb_top.sv: self-checking bench for bad_top
// assumes bad_top, bad_partner and the bound checker are compiled
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH %0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  reg clk, rst, cpuCmd, cpuBhe, pageEnable, pageLoad, busGranted, sawReq;
  reg overlay_inhibit, clrReq;
  reg [2:0] cpuStatus;
  reg [19:0] cpuAddr;
  reg [3:0] pageData;
  reg [5:0] rangeSetting;
  wire [19:0] slvAddr;
  wire [3:0] slvPage, romEnable, sharedHighAddr;
  wire [8:0] ioSelect;
  wire [23:0] busAddr;
  wire slvRead, slvWrite, offboard_address_drive, spaceMem, ramSelect;
  wire rom_hit, command_decode_enable, romRead, portHit, ctrlRead, ctrlWrite;
  wire onboard_address_valid, status_register_select, slaveCommandGate;
  wire bus_address_drive_enable, onboard_command_gate, shared_ram_enable;
  wire local_shared_read, local_shared_write, offboard_address_request;
  integer fails, checked;
  bad_top i_bad_top (.clk, .rst, .cpuStatus, .cpuAddr, .cpuCmd, .cpuBhe,
    .pageEnable, .pageLoad, .pageData, .busGranted, .slvAddr, .slvRead,
    .slvWrite, .slvPage, .rangeSetting, .offboard_address_drive,
    .overlay_inhibit, .spaceMem, .ramSelect, .romEnable, .rom_hit,
    .command_decode_enable, .romRead, .ioSelect, .portHit,
    .onboard_address_valid, .status_register_select, .busAddr,
    .bus_address_drive_enable, .onboard_command_gate, .slaveCommandGate,
    .shared_ram_enable, .local_shared_read, .local_shared_write, .ctrlRead,
    .ctrlWrite, .offboard_address_request, .sharedHighAddr);
  bad_partner i_bad_partner (.clk, .rst, .offboard_address_request,
    .slvAddr, .slvPage, .slvRead, .slvWrite, .offboard_address_drive);
  // sticky record of slave requests, cleared by the bench
  always @(posedge clk) begin
    sawReq <= !clrReq && (sawReq || offboard_address_request);
  end
  task cyc(input [2:0] st, input [19:0] a, input c);
    @(posedge clk);
    cpuStatus <= st;
    cpuAddr <= a;
    cpuCmd <= c;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task t_io;
    reg [8:0] seen;
    integer i;
    seen = 9'h0;
    for (i = 0; i < 9; i++) begin
      cyc(3'h1, 20'hc0 + i * 8, 1'b1);
      `CHK(ioSelect != 0 && (ioSelect & (ioSelect - 1)) == 0, 1'b1)
      `CHK(portHit, 1'b1)
      `CHK(ioSelect & seen, 9'h0)
      seen = seen | ioSelect;
    end
    `CHK(status_register_select, 1'b1)
    `CHK(seen, 9'h1ff)
    cyc(3'h1, 20'hc1, 1'b1);
    `CHK({ioSelect, onboard_address_valid}, 10'h0)
  endtask
  task t_mem;
    cyc(3'h5, 20'h01234, 1'b1);
    `CHK({spaceMem, ramSelect, rom_hit, ioSelect}, 12'hc00)
    `CHK({onboard_command_gate, shared_ram_enable, ctrlRead}, 3'h7)
    `CHK({local_shared_read, local_shared_write}, 2'h2)
    cyc(3'h6, 20'h01234, 1'b1);
    `CHK({local_shared_write, ctrlWrite}, 2'h3)
    cyc(3'h5, 20'hffffe, 1'b1);
    `CHK({rom_hit, ramSelect, command_decode_enable, romRead}, 4'hb)
    `CHK(romEnable[3:2] | romEnable[1:0], 2'h3)
    `CHK(romEnable, 4'hc)
  endtask
  task t_page;
    @(posedge clk);
    pageData <= 4'ha;
    pageLoad <= 1'b1;
    pageEnable <= 1'b1;
    busGranted <= 1'b1;
    @(posedge clk);
    pageLoad <= 1'b0;
    cyc(3'h5, 20'h90010, 1'b1);
    `CHK({bus_address_drive_enable, busAddr}, 25'h1a90010)
    @(posedge clk);
    pageEnable <= 1'b0;
    cyc(3'h5, 20'h90010, 1'b1);
    `CHK(busAddr, 24'h090010)
    @(posedge clk);
    busGranted <= 1'b0;
    cyc(3'h5, 20'h90010, 1'b1);
    `CHK(bus_address_drive_enable, 1'b0)
  endtask
  task t_slave;
    cyc(3'h7, 20'h0, 1'b0);
    @(posedge clk);
    rangeSetting <= 6'h13;
    overlay_inhibit <= 1'b1;
    clrReq <= 1'b1;
    @(posedge clk);
    clrReq <= 1'b0;
    i_bad_partner.access(20'h00800, 4'ha, 1'b0);
    `CHK(sawReq, 1'b0)
    @(posedge clk);
    overlay_inhibit <= 1'b0;
    fork
      i_bad_partner.access(20'h00800, 4'ha, 1'b0);
      begin
        repeat (4) @(posedge clk);
        #1;
        `CHK({offboard_address_request, slaveCommandGate}, 2'h3)
        `CHK({shared_ram_enable, ctrlRead, ctrlWrite}, 3'h6)
        `CHK(onboard_command_gate, 1'b0)
        repeat (2) @(posedge clk);
        #1;
        `CHK(sharedHighAddr, 4'h3)
      end
    join
    fork
      i_bad_partner.access(20'h00800, 4'ha, 1'b1);
      begin
        repeat (4) @(posedge clk);
        #1;
        `CHK({slaveCommandGate, ctrlWrite, ctrlRead}, 3'h6)
      end
    join
    @(posedge clk);
    clrReq <= 1'b1;
    @(posedge clk);
    clrReq <= 1'b0;
    i_bad_partner.access(20'hffff0, 4'ha, 1'b0);
    `CHK(sawReq, 1'b0)
    `CHK({romRead, slaveCommandGate}, 2'h0)
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    fails++;
    final_report;
  end
  initial begin
    {rst, cpuStatus, cpuAddr, cpuCmd, cpuBhe} = {1'b1, 3'h7, 20'h0, 2'h0};
    {pageEnable, pageLoad, pageData, busGranted} = 7'h0;
    {overlay_inhibit, rangeSetting, clrReq} = 8'h0;
    fails = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK({ioSelect, ramSelect, romEnable}, 14'h0)
    t_io;
    t_mem;
    t_page;
    t_slave;
    final_report;
  end
endmodule
